// ==== rtl/asd_consts.svh ====
/*
 * Address map, region bounds and sizes of the address space decoder.
 * Assumes a 16-bit byte address and 16-bit words, low byte at the even address.
 */
`ifndef ASD_CONSTS_SVH
`define ASD_CONSTS_SVH

// flat 64 KB byte address space
`define ASD_ADDR_W 16
`define ASD_DATA_W 16
`define ASD_SFR_LO 16'h0000
`define ASD_SFR_HI 16'h000F
`define ASD_P8_LO 16'h0010
`define ASD_P8_HI 16'h00FF
`define ASD_P16_LO 16'h0100
`define ASD_P16_HI 16'h01FF
`define ASD_RAM_LO 16'h0200
// build-time sizes: 512 bytes of ram, program memory from F000h to the top
`define ASD_RAM_BYTES 16'h0200
`define ASD_PROG_LO 16'hF000
`define ASD_TOP 16'hFFFF
`define ASD_RAM_WORDS 256
`define ASD_RAM_IW 8
`define ASD_PROG_WORDS 2048
`define ASD_PROG_IW 11
// vector table: top 16 words, highest priority at FFFEh
`define ASD_VEC_LO 16'hFFE0
`define ASD_RESET_VEC 16'hFFFE
`define ASD_VEC_W 4
// special function bytes below this offset hold storage, the rest only pulse
`define ASD_SFR_STORED 4'h8
`define ASD_SFR_N 8
`define ASD_SFR_IW 3
`define ASD_PC_STEP 16'h0002
`define ASD_BYTE_ZERO 8'h00
`define ASD_WORD_ZERO 16'h0000

`endif

// ==== rtl/asd_pkg.sv ====
/*
 * Types shared by both ends of the address space decoder.
 * Assumes asd_consts.svh is on the include path.
 */
`include "asd_consts.svh"

package asd_pkg;

    typedef enum logic [1:0] {
        ASD_H_BOOT,
        ASD_H_BOOT_WAIT,
        ASD_H_IDLE,
        ASD_H_WAIT
    } asd_hstate_t;

    typedef struct packed {
        logic [`ASD_DATA_W-1:0] rdata;
        logic ack;
        logic [`ASD_SFR_N-1:0][7:0] special_function_register;
        logic [7:0] pulse;
        logic [`ASD_SFR_IW-1:0] pulse_idx;
        logic vec_hit;
        logic [`ASD_VEC_W-1:0] vec_num;
    } asd_dev_t;

    typedef struct packed {
        asd_hstate_t state;
        logic [`ASD_ADDR_W-1:0] pc;
        logic load_pc;
        logic boot_done;
        logic req;
        logic we;
        logic byte_acc;
        logic fetch;
        logic [`ASD_ADDR_W-1:0] addr;
        logic [`ASD_DATA_W-1:0] wdata;
        logic rsp_valid;
        logic [`ASD_DATA_W-1:0] rsp_rdata;
    } asd_host_t;

endpackage

// ==== rtl/asd_bus_if.sv ====
/*
 * Memory address and data bus between the requester and the decoder.
 * Assumes both ends run on the same mclk; no clocking block.
 */
`timescale 1ns/100ps
`include "asd_consts.svh"

interface asd_bus_if;
    logic req;
    logic we;
    logic byte_acc;
    logic fetch;
    logic [`ASD_ADDR_W-1:0] memory_address_bus;
    logic [`ASD_DATA_W-1:0] memory_data_bus_wr;
    logic ack;
    logic [`ASD_DATA_W-1:0] memory_data_bus_rd;

    modport host (
        output req,
        output we,
        output byte_acc,
        output fetch,
        output memory_address_bus,
        output memory_data_bus_wr,
        input ack,
        input memory_data_bus_rd
    );

    modport dev (
        input req,
        input we,
        input byte_acc,
        input fetch,
        input memory_address_bus,
        input memory_data_bus_wr,
        output ack,
        output memory_data_bus_rd
    );
endinterface

// ==== rtl/asd_decoder.sv ====
/*
 * Address space decoder: steers each mapped bus access to the special function
 * registers, the 8-bit or 16-bit peripheral region, ram or program memory.
 * Assumes one access in flight at a time and a single mclk domain; program
 * memory is filled through the loader port, cpu writes to it are dropped.
 */
`timescale 1ns/100ps
`include "asd_consts.svh"

module asd_decoder
    import asd_pkg::*;
(
    // clock and power-up clear
    input wire logic mclk,
    input wire logic rstn,
    // bus from the requester
    asd_bus_if.dev bus,
    // 8-bit peripheral region
    output logic p8_sel,
    output logic p8_we,
    output logic [7:0] p8_addr,
    output logic [7:0] p8_wdata,
    input wire logic [7:0] p8_rdata,
    // 16-bit peripheral region
    output logic p16_sel,
    output logic p16_we,
    output logic p16_byte,
    output logic [7:0] p16_addr,
    output logic [`ASD_DATA_W-1:0] p16_wdata,
    input wire logic [`ASD_DATA_W-1:0] p16_rdata,
    // special function register contents and write pulses
    output logic [`ASD_SFR_N-1:0][7:0] sfr_q,
    output logic [7:0] sfr_pulse,
    output logic [`ASD_SFR_IW-1:0] sfr_pulse_idx,
    // vector table access status
    output logic vec_hit,
    output logic [`ASD_VEC_W-1:0] vec_num,
    // program memory loader
    input wire logic load_we,
    input wire logic [`ASD_PROG_IW-1:0] load_addr,
    input wire logic [`ASD_DATA_W-1:0] load_data
);

    asd_dev_t q_ff;
    asd_dev_t nxt_q;

    logic [`ASD_DATA_W-1:0] ram_mem [0:`ASD_RAM_WORDS-1];
    logic [`ASD_DATA_W-1:0] prog_mem [0:`ASD_PROG_WORDS-1];

    logic [`ASD_ADDR_W-1:0] addr;
    logic [`ASD_ADDR_W-1:0] ram_off;
    logic [`ASD_ADDR_W-1:0] prog_off;
    logic [`ASD_ADDR_W-1:0] vec_off;
    logic in_sfr;
    logic in_p8;
    logic in_p16;
    logic in_ram;
    logic in_prog;
    logic [`ASD_RAM_IW-1:0] ram_idx;
    logic [`ASD_PROG_IW-1:0] prog_idx;
    logic [`ASD_SFR_IW-1:0] sfr_idx;
    logic [`ASD_DATA_W-1:0] ram_word;
    logic [`ASD_DATA_W-1:0] prog_word;
    logic [`ASD_DATA_W-1:0] mem_wd;
    logic wr_lo;
    logic wr_hi;
    logic ram_wr;

    // region decode on the full 16-bit address, no io space
    assign addr = bus.memory_address_bus;
    assign in_sfr = (addr <= `ASD_SFR_HI);
    assign in_p8 = (addr >= `ASD_P8_LO) && (addr <= `ASD_P8_HI);
    assign in_p16 = (addr >= `ASD_P16_LO) && (addr <= `ASD_P16_HI);
    assign in_ram = (addr >= `ASD_RAM_LO) && (addr < (`ASD_RAM_LO + `ASD_RAM_BYTES));
    assign in_prog = (addr >= `ASD_PROG_LO);

    assign ram_off = addr - `ASD_RAM_LO;
    assign prog_off = addr - `ASD_PROG_LO;
    assign vec_off = `ASD_RESET_VEC - {addr[`ASD_ADDR_W-1:1], 1'b0};
    // word index drops bit 0, so a word always pairs an even and odd byte
    assign ram_idx = ram_off[`ASD_RAM_IW:1];
    assign prog_idx = prog_off[`ASD_PROG_IW:1];
    assign sfr_idx = addr[`ASD_SFR_IW-1:0];
    assign ram_word = ram_mem[ram_idx];
    assign prog_word = prog_mem[prog_idx];

    // byte writes replicate the low data byte onto the addressed lane
    assign wr_lo = !bus.byte_acc || !addr[0];
    assign wr_hi = !bus.byte_acc || addr[0];
    assign mem_wd = bus.byte_acc ? {bus.memory_data_bus_wr[7:0], bus.memory_data_bus_wr[7:0]}
                                 : bus.memory_data_bus_wr;
    // fetches are never writes, so code and data share ram alike
    assign ram_wr = bus.req && bus.we && !bus.fetch && in_ram;

    // peripheral strobes follow the request in the same cycle
    assign p8_sel = bus.req && in_p8;
    assign p8_we = bus.req && bus.we && in_p8;
    assign p8_addr = addr[7:0];
    // only the low data byte reaches a byte peripheral
    assign p8_wdata = bus.memory_data_bus_wr[7:0];
    assign p16_sel = bus.req && in_p16;
    assign p16_we = bus.req && bus.we && in_p16;
    assign p16_byte = bus.byte_acc;
    assign p16_addr = addr[7:0];
    assign p16_wdata = bus.memory_data_bus_wr;

    always_comb begin
        nxt_q = q_ff;
        nxt_q.ack = 1'b0;
        nxt_q.pulse = `ASD_BYTE_ZERO;
        if (bus.req) begin
            nxt_q.ack = 1'b1;
            nxt_q.rdata = `ASD_WORD_ZERO;
            nxt_q.vec_hit = in_prog && (addr >= `ASD_VEC_LO);
            nxt_q.vec_num = vec_off[`ASD_VEC_W:1];
            if (in_sfr) begin
                // byte organised; a word access still only touches one byte
                // the full byte offset is compared: the 3-bit index alone would wrap 8..15 onto 0..7
                if (addr[`ASD_SFR_IW:0] < `ASD_SFR_STORED) begin
                    if (bus.we) begin
                        nxt_q.special_function_register[sfr_idx] = bus.memory_data_bus_wr[7:0];
                    end else begin
                        nxt_q.rdata = {`ASD_BYTE_ZERO, q_ff.special_function_register[sfr_idx]};
                    end
                end else if (bus.we) begin
                    // no storage: ones written give a one-cycle pulse, read stays zero
                    nxt_q.pulse = bus.memory_data_bus_wr[7:0];
                    nxt_q.pulse_idx = sfr_idx;
                end
            end else if (in_p8) begin
                // high byte of a word read is undefined; zero is what we give
                nxt_q.rdata = {`ASD_BYTE_ZERO, p8_rdata};
            end else if (in_p16) begin
                if (bus.byte_acc) begin
                    nxt_q.rdata = {`ASD_BYTE_ZERO, p16_rdata[7:0]};
                end else begin
                    nxt_q.rdata = p16_rdata;
                end
            end else if (in_ram) begin
                if (bus.byte_acc) begin
                    nxt_q.rdata = {`ASD_BYTE_ZERO, addr[0] ? ram_word[15:8] : ram_word[7:0]};
                end else begin
                    nxt_q.rdata = ram_word;
                end
            end else if (in_prog) begin
                // reset vector and code come from here on the same path
                if (bus.byte_acc) begin
                    nxt_q.rdata = {`ASD_BYTE_ZERO, addr[0] ? prog_word[15:8] : prog_word[7:0]};
                end else begin
                    nxt_q.rdata = prog_word;
                end
            end
            // anything else is unclaimed: rdata stays zero, writes dropped
            if (bus.we) begin
                nxt_q.rdata = `ASD_WORD_ZERO;
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            q_ff <= '0;
        end else begin
            q_ff <= nxt_q;
        end
    end

    // memories hold no reset value; a reset must not wipe loaded code
    always_ff @(posedge mclk) begin
        if (ram_wr) begin
            if (wr_lo) begin
                ram_mem[ram_idx][7:0] <= mem_wd[7:0];
            end
            if (wr_hi) begin
                ram_mem[ram_idx][15:8] <= mem_wd[15:8];
            end
        end
        if (load_we) begin
            prog_mem[load_addr] <= load_data;
        end
    end

    assign bus.ack = q_ff.ack;
    assign bus.memory_data_bus_rd = q_ff.rdata;
    assign sfr_q = q_ff.special_function_register;
    assign sfr_pulse = q_ff.pulse;
    assign sfr_pulse_idx = q_ff.pulse_idx;
    assign vec_hit = q_ff.vec_hit;
    assign vec_num = q_ff.vec_num;

endmodule

// ==== rtl/asd_requester.sv ====
/*
 * Requester end: boots the program counter from the reset vector, then
 * issues fetches, vector loads and data accesses, aligned per region.
 * Assumes the decoder answers every request with ack one cycle later.
 */
`timescale 1ns/100ps
`include "asd_consts.svh"

module asd_requester
    import asd_pkg::*;
(
    // clock and power-up clear
    input wire logic mclk,
    input wire logic rstn,
    // bus to the decoder
    asd_bus_if.host bus,
    // command port
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_we,
    input wire logic cmd_byte,
    input wire logic cmd_fetch,
    input wire logic cmd_vec,
    input wire logic [`ASD_VEC_W-1:0] cmd_vec_num,
    input wire logic [`ASD_ADDR_W-1:0] cmd_addr,
    input wire logic [`ASD_DATA_W-1:0] cmd_wdata,
    // response and state
    output logic rsp_valid,
    output logic [`ASD_DATA_W-1:0] rsp_rdata,
    output logic [`ASD_ADDR_W-1:0] program_counter,
    output logic boot_done
);

    asd_host_t q_ff;
    asd_host_t nxt_q;
    logic [`ASD_ADDR_W-1:0] a;
    logic bsz;

    always_comb begin
        nxt_q = q_ff;
        nxt_q.req = 1'b0;
        nxt_q.rsp_valid = 1'b0;
        a = cmd_addr;
        bsz = cmd_byte;
        // special function and byte peripheral regions take bytes only
        if (a <= `ASD_P8_HI) begin
            bsz = 1'b1;
        end
        // words even; bytes in the 16-bit region even as well
        if (!bsz || ((a >= `ASD_P16_LO) && (a <= `ASD_P16_HI))) begin
            a[0] = 1'b0;
        end
        case (q_ff.state)
            ASD_H_BOOT: begin
                // first word after reset comes from the reset vector
                nxt_q.req = 1'b1;
                nxt_q.we = 1'b0;
                nxt_q.byte_acc = 1'b0;
                nxt_q.fetch = 1'b0;
                nxt_q.addr = `ASD_RESET_VEC;
                nxt_q.load_pc = 1'b1;
                nxt_q.state = ASD_H_BOOT_WAIT;
            end
            ASD_H_BOOT_WAIT, ASD_H_WAIT: begin
                if (bus.ack) begin
                    if (q_ff.load_pc) begin
                        nxt_q.pc = {bus.memory_data_bus_rd[15:1], 1'b0};
                        nxt_q.boot_done = 1'b1;
                    end else begin
                        nxt_q.rsp_valid = 1'b1;
                    end
                    nxt_q.rsp_rdata = bus.memory_data_bus_rd;
                    nxt_q.load_pc = 1'b0;
                    nxt_q.state = ASD_H_IDLE;
                end
            end
            default: begin
                if (cmd_valid) begin
                    nxt_q.req = 1'b1;
                    nxt_q.state = ASD_H_WAIT;
                    nxt_q.wdata = cmd_wdata;
                    if (cmd_vec) begin
                        // vector n sits n words below FFFEh
                        nxt_q.we = 1'b0;
                        nxt_q.byte_acc = 1'b0;
                        nxt_q.fetch = 1'b0;
                        nxt_q.addr = `ASD_RESET_VEC - {11'h000, cmd_vec_num, 1'b0};
                        nxt_q.load_pc = 1'b1;
                    end else if (cmd_fetch) begin
                        // code is always read as an even word
                        nxt_q.we = 1'b0;
                        nxt_q.byte_acc = 1'b0;
                        nxt_q.fetch = 1'b1;
                        nxt_q.addr = q_ff.pc;
                        nxt_q.pc = q_ff.pc + `ASD_PC_STEP;
                    end else begin
                        nxt_q.we = cmd_we;
                        nxt_q.byte_acc = bsz;
                        nxt_q.fetch = 1'b0;
                        nxt_q.addr = a;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            q_ff <= '0;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign cmd_ready = (q_ff.state == ASD_H_IDLE);
    assign bus.req = q_ff.req;
    assign bus.we = q_ff.we;
    assign bus.byte_acc = q_ff.byte_acc;
    assign bus.fetch = q_ff.fetch;
    assign bus.memory_address_bus = q_ff.addr;
    assign bus.memory_data_bus_wr = q_ff.wdata;
    assign rsp_valid = q_ff.rsp_valid;
    assign rsp_rdata = q_ff.rsp_rdata;
    assign program_counter = q_ff.pc;
    assign boot_done = q_ff.boot_done;

endmodule

// ==== tb/asd_bus_properties.sv ====
/*
 * Checker for the bus between requester and decoder.
 * Assumes the signals of asd_bus_if, one mclk domain and rstn active low.
 */
`timescale 1ns/100ps
`include "asd_consts.svh"

module asd_bus_properties (
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // request side
    input wire logic req,
    input wire logic we,
    input wire logic byte_acc,
    input wire logic fetch,
    input wire logic [`ASD_ADDR_W-1:0] memory_address_bus,
    input wire logic [`ASD_DATA_W-1:0] memory_data_bus_wr,
    // answer side
    input wire logic ack,
    input wire logic [`ASD_DATA_W-1:0] memory_data_bus_rd
);
    default clocking dc @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    // first request after each reset must be the reset vector load
    logic boot_seen_ff;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            boot_seen_ff <= 1'b0;
        end else if (req) begin
            boot_seen_ff <= 1'b1;
        end
    end

    AST_ACK_NEXT: assert property (req |=> ack)
        else $error("no ack one cycle after req");
    AST_ACK_CAUSE: assert property (ack |-> $past(req))
        else $error("ack without req");
    AST_REQ_SPACING: assert property (req |=> !req ##1 !req)
        else $error("requests closer than three cycles");
    AST_FETCH_EVEN: assert property (req && fetch |-> !memory_address_bus[0] && !byte_acc && !we)
        else $error("fetch not an even word read");
    AST_WORD_EVEN: assert property (req && !byte_acc |-> !memory_address_bus[0])
        else $error("word access at odd address");
    AST_BYTE_HI_ZERO: assert property (req && !we && byte_acc |=> memory_data_bus_rd[15:8] == 8'h00)
        else $error("byte read with nonzero high byte");
    AST_P16_BYTE_EVEN: assert property (req && byte_acc && memory_address_bus[15:8] == 8'h01 |-> !memory_address_bus[0])
        else $error("odd byte access in word peripheral region");
    AST_LOW_BYTE_ONLY: assert property (req && memory_address_bus <= 16'h00FF |-> byte_acc)
        else $error("word access below 0100h");
    AST_UNMAPPED_ZERO: assert property (req && !we && memory_address_bus inside {[16'h0400:16'hEFFF]}
        |=> memory_data_bus_rd == 16'h0000)
        else $error("unmapped read not zero");
    AST_BOOT_VEC: assert property (req && !boot_seen_ff |-> memory_address_bus == 16'hFFFE && !we)
        else $error("first request not the reset vector");
endmodule

// ==== tb/address_space_decoder_tb_top.sv ====
/*
 * Testbench: requester and decoder joined by asd_bus_if, driven via commands.
 * Assumes program memory is preloaded through the loader while rstn is low.
 */
`timescale 1ns/100ps
`include "asd_consts.svh"

module address_space_decoder_tb_top
    import asd_pkg::*;
;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] p8_rdata = 8'h00;
    logic [15:0] p16_rdata = 16'h0000;
    logic load_we = 1'b0;
    logic [10:0] load_addr = 11'h000;
    logic [15:0] load_data = 16'h0000;
    logic cmd_valid = 1'b0;
    logic cmd_we = 1'b0;
    logic cmd_byte = 1'b0;
    logic cmd_fetch = 1'b0;
    logic cmd_vec = 1'b0;
    logic [3:0] cmd_vec_num = 4'h0;
    logic [15:0] cmd_addr = 16'h0000;
    logic [15:0] cmd_wdata = 16'h0000;
    logic p8_sel, p8_we, p16_sel, p16_we, p16_byte, vec_hit, cmd_ready, rsp_valid, boot_done;
    logic [7:0] p8_addr, p8_wdata, p16_addr, sfr_pulse;
    logic [15:0] p16_wdata, rsp_rdata, program_counter, p8_seen, p16_seen, pulse_seen;
    logic [`ASD_SFR_N-1:0][7:0] sfr_q;
    logic [2:0] sfr_pulse_idx;
    logic [3:0] vec_num;
    int error_cnt = 0;
    int compares = 0;
    int pulse_cyc = 0;
    int p16_cnt = 0;

    always #25 mclk = ~mclk;

    asd_bus_if i_asd_bus_if();
    asd_decoder i_asd_decoder (.mclk(mclk), .rstn(rstn), .bus(i_asd_bus_if), .p8_sel(p8_sel), .p8_we(p8_we),
        .p8_addr(p8_addr), .p8_wdata(p8_wdata), .p8_rdata(p8_rdata), .p16_sel(p16_sel), .p16_we(p16_we),
        .p16_byte(p16_byte), .p16_addr(p16_addr), .p16_wdata(p16_wdata), .p16_rdata(p16_rdata), .sfr_q(sfr_q),
        .sfr_pulse(sfr_pulse), .sfr_pulse_idx(sfr_pulse_idx), .vec_hit(vec_hit), .vec_num(vec_num),
        .load_we(load_we), .load_addr(load_addr), .load_data(load_data));
    asd_requester i_asd_requester (.mclk(mclk), .rstn(rstn), .bus(i_asd_bus_if), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_we(cmd_we), .cmd_byte(cmd_byte), .cmd_fetch(cmd_fetch), .cmd_vec(cmd_vec),
        .cmd_vec_num(cmd_vec_num), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .program_counter(program_counter), .boot_done(boot_done));
    asd_bus_properties i_asd_bus_properties (.mclk(mclk), .rstn(rstn), .req(i_asd_bus_if.req),
        .we(i_asd_bus_if.we), .byte_acc(i_asd_bus_if.byte_acc), .fetch(i_asd_bus_if.fetch),
        .memory_address_bus(i_asd_bus_if.memory_address_bus), .memory_data_bus_wr(i_asd_bus_if.memory_data_bus_wr),
        .ack(i_asd_bus_if.ack), .memory_data_bus_rd(i_asd_bus_if.memory_data_bus_rd));

    // peripheral strobes are combinational, so capture them at the edge
    always @(posedge mclk) begin
        if (p8_sel === 1'b1 && p8_we === 1'b1) begin
            p8_seen <= {p8_addr, p8_wdata};
        end
        if (p16_sel === 1'b1) begin
            p16_cnt <= p16_cnt + 1;
            p16_seen <= p16_wdata;
        end
        if (sfr_pulse !== 8'h00) begin
            pulse_seen <= {5'h00, sfr_pulse_idx, sfr_pulse};
            pulse_cyc <= pulse_cyc + 1;
        end
    end

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            $display("BAD %s expected %h seen %h", what, exp, seen);
            error_cnt++;
        end
    endtask

    task automatic do_cmd(input logic w, b, f, v, input logic [3:0] vn, input logic [15:0] a, d);
        int n;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 50) begin
            @(posedge mclk);
            #1 n++;
        end
        @(posedge mclk);
        cmd_valid <= 1'b1;
        {cmd_we, cmd_byte, cmd_fetch, cmd_vec, cmd_vec_num, cmd_addr, cmd_wdata} <= {w, b, f, v, vn, a, d};
        @(posedge mclk);
        cmd_valid <= 1'b0;
        n = 0;
        do begin
            @(posedge mclk);
            #1 n++;
        end while (cmd_ready !== 1'b1 && n < 50);
        chk("cmd_ready", {15'h0000, cmd_ready}, 16'h0001);
    endtask

    task automatic rd(input logic [15:0] a, input logic b, input logic [15:0] exp);
        do_cmd(1'b0, b, 1'b0, 1'b0, 4'h0, a, 16'h0000);
        chk("rsp_valid", {15'h0000, rsp_valid}, 16'h0001);
        chk("rsp_rdata", rsp_rdata, exp);
    endtask

    task automatic reset_dut(input logic preload);
        @(posedge mclk);
        rstn <= 1'b0;
        load_we <= preload;
        // reset vector, first fetch word, vector 1
        {load_addr, load_data} <= {11'h7FF, 16'hF010};
        @(posedge mclk);
        {load_addr, load_data} <= {11'h008, 16'h1234};
        @(posedge mclk);
        {load_addr, load_data} <= {11'h7FE, 16'hABCD};
        @(posedge mclk);
        load_we <= 1'b0;
        repeat (9) @(posedge mclk);
        rstn <= 1'b1;
        repeat (20) @(posedge mclk);
        chk("boot_done", {15'h0000, boot_done}, 16'h0001);
        chk("pc", program_counter, 16'hF010);
        chk("vec_hit", {15'h0000, vec_hit}, 16'h0001);
        chk("vec_num", {12'h000, vec_num}, 16'h0000);
        $display("test boot done");
    endtask

    task automatic t_fetch_vec();
        do_cmd(1'b0, 1'b0, 1'b1, 1'b0, 4'h0, 16'h0000, 16'h0000);
        chk("fetch data", rsp_rdata, 16'h1234);
        chk("pc step", program_counter, 16'hF012);
        chk("vec_hit off", {15'h0000, vec_hit}, 16'h0000);
        do_cmd(1'b0, 1'b0, 1'b0, 1'b1, 4'h1, 16'h0000, 16'h0000);
        chk("pc vec", program_counter, 16'hABCC);
        chk("vec_num", {12'h000, vec_num}, 16'h0001);
        $display("test fetch and vector done");
    endtask

    task automatic t_ram();
        do_cmd(1'b1, 1'b0, 1'b0, 1'b0, 4'h0, 16'h0200, 16'hA55A);
        do_cmd(1'b1, 1'b1, 1'b0, 1'b0, 4'h0, 16'h03FF, 16'h003C);
        rd(16'h0200, 1'b0, 16'hA55A);
        rd(16'h0201, 1'b1, 16'h00A5);
        rd(16'h03FF, 1'b1, 16'h003C);
        $display("test ram done");
    endtask

    task automatic t_periph();
        int c;
        c = p16_cnt;
        p16_rdata <= 16'hBEEF;
        p8_rdata <= 8'h5A;
        rd(16'h0180, 1'b0, 16'hBEEF);
        rd(16'h0101, 1'b1, 16'h00EF);
        do_cmd(1'b1, 1'b0, 1'b0, 1'b0, 4'h0, 16'h0102, 16'hC0DE);
        chk("p16 wdata", p16_seen, 16'hC0DE);
        chk("p16 selects", 16'(p16_cnt - c), 16'h0003);
        rd(16'h0041, 1'b0, 16'h005A);
        do_cmd(1'b1, 1'b0, 1'b0, 1'b0, 4'h0, 16'h0041, 16'h1234);
        chk("p8 write", p8_seen, 16'h4134);
        $display("test peripherals done");
    endtask

    task automatic t_sfr();
        int c;
        do_cmd(1'b1, 1'b1, 1'b0, 1'b0, 4'h0, 16'h0003, 16'h0096);
        chk("sfr byte", {8'h00, sfr_q[3]}, 16'h0096);
        rd(16'h0003, 1'b1, 16'h0096);
        c = pulse_cyc;
        do_cmd(1'b1, 1'b1, 1'b0, 1'b0, 4'h0, 16'h000A, 16'h0005);
        chk("pulse", pulse_seen, 16'h0205);
        chk("pulse length", 16'(pulse_cyc - c), 16'h0001);
        rd(16'h000A, 1'b1, 16'h0000);
        $display("test special registers done");
    endtask

    task automatic t_unmapped();
        do_cmd(1'b1, 1'b0, 1'b0, 1'b0, 4'h0, 16'h1000, 16'hFFFF);
        rd(16'h1000, 1'b0, 16'h0000);
        do_cmd(1'b1, 1'b0, 1'b0, 1'b0, 4'h0, 16'hF010, 16'h0000);
        rd(16'hF010, 1'b0, 16'h1234);
        $display("test unmapped done");
    endtask

    task automatic final_report();
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        reset_dut(1'b1);
        t_fetch_vec();
        t_ram();
        t_periph();
        t_sfr();
        t_unmapped();
        // second reset mid-run: flops clear, ram keeps its contents
        reset_dut(1'b0);
        chk("sfr after reset", {8'h00, sfr_q[3]}, 16'h0000);
        rd(16'h0200, 1'b0, 16'hA55A);
        final_report();
    end

    initial begin
        repeat (3000) @(posedge mclk);
        error_cnt++;
        $display("watchdog expired");
        final_report();
    end
endmodule
